/* src/cbt_pkg.sv */
// Shared constants, bus carriers and timing types for the bus timing block.
package cbt_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMING_OFS = 8'h04;
  localparam logic [7:0] INT_OFS = 8'h08;

  // Control register fields.
  localparam int ON_BIT = 15;
  localparam int OPMODE_LSB = 21;
  localparam logic [2:0] OPMODE_CONFIG = 3'h4;
  localparam logic [2:0] OPMODE_RST = 3'h0;

  // Bit timing register fields.
  localparam int WAKEFILT_BIT = 22;
  localparam int P2LEN_LSB = 16;
  localparam int P2SEL_BIT = 15;
  localparam int TRIPLE_BIT = 14;
  localparam int P1LEN_LSB = 11;
  localparam int LOW_W = 11;
  localparam logic [31:0] TIMING_MASK = 32'h0047_FFFF;
  localparam logic [31:0] TIMING_RST = 32'h0000_0000;

  // Information processing time in quanta, and its segment code.
  localparam logic [3:0] IPT_QUANTA = 4'h2;
  localparam logic [2:0] IPT_CODE = 3'h1;

  // Interrupt register fields.
  localparam logic [31:0] INT_MASK = 32'hF80F_F80F;
  localparam logic [15:0] FLAG_MASK = 16'hF80F;
  localparam logic [31:0] INT_RST = 32'h0000_0000;
  localparam int INVALID_FLAG = 15;
  localparam int WAKE_FLAG = 14;
  localparam int SYSERR_FLAG = 12;
  localparam int MODE_FLAG = 3;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Wake-up line filter: the line must stay dominant this long.
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FILT_NS = 50;
  localparam logic [3:0] WAKE_FILT_CYC =
    4'((WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic wakeFilterEn;
    logic tripleSampleEn;
    logic [3:0] phase1Quanta;
    logic [3:0] phase2Quanta;
    logic [10:0] lowBits;
  } timing_s;

  // Derived timing while the bit timing register holds its reset value.
  localparam timing_s CFG_RST = '{
    wakeFilterEn: 1'b0,
    tripleSampleEn: 1'b0,
    phase1Quanta: 4'h1,
    phase2Quanta: 4'h2,
    lowBits: 11'h000
  };

endpackage

/* src/cbt_rx_sampler.sv */
// Bus line sampler with triple-sample vote and wake-up line filter.
`timescale 1ns/1ps
module cbt_rx_sampler (
  // Clock and reset
  input wire logic clock,
  input wire logic rstSyncN,
  // Bus line
  input wire logic rxLine,
  input wire logic sampleStrobe,
  // Configuration
  input wire logic tripleEn,
  input wire logic filterEn,
  // Results
  output logic sampledBit,
  output logic wakeEvent
);

  typedef struct packed {
    logic [1:0] hist;
    logic bitOut;
    logic [3:0] lowCnt;
    logic rxPrev;
    logic wake;
  } cbt_samp_s;

  cbt_samp_s s_r;
  cbt_samp_s s_nxt;
  logic vote;

  assign vote = (s_r.hist[1] & s_r.hist[0]) | (s_r.hist[1] & rxLine) |
                (s_r.hist[0] & rxLine);

  always_comb begin
    s_nxt = s_r;
    s_nxt.hist = {s_r.hist[0], rxLine};
    s_nxt.rxPrev = rxLine;
    if (sampleStrobe) begin
      s_nxt.bitOut = tripleEn ? vote : rxLine;
    end
    if (rxLine) begin
      s_nxt.lowCnt = 4'h0;
    end else if (s_r.lowCnt != cbt_pkg::WAKE_FILT_CYC) begin
      s_nxt.lowCnt = s_r.lowCnt + 4'h1;
    end
    // A dominant edge wakes at once; with the filter it must persist.
    if (filterEn) begin
      s_nxt.wake = !rxLine &&
        (s_r.lowCnt == cbt_pkg::WAKE_FILT_CYC - 4'h1);
    end else begin
      s_nxt.wake = s_r.rxPrev && !rxLine;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sampledBit = s_r.bitOut;
  assign wakeEvent = s_r.wake;

  triple_vote_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    sampleStrobe && tripleEn |=> sampledBit == $past(vote))
    else $error("triple sample vote wrong");
  single_sample_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    sampleStrobe && !tripleEn |=> sampledBit == $past(rxLine))
    else $error("single sample wrong");
  wake_raw_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    !filterEn && s_r.rxPrev && !rxLine |=> wakeEvent)
    else $error("unfiltered wake missed");
  wake_filter_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    wakeEvent && $past(filterEn) |-> $past(!rxLine, 1) && $past(!rxLine, 5))
    else $error("filtered wake too early");
  triple_seen_c: cover property (@(posedge clock) disable iff (!rstSyncN)
    sampleStrobe && tripleEn);

endmodule

/* src/cbt_can_cfg_top.sv */
// Bus timing and interrupt register block with an AXI4-Lite slave.
`timescale 1ns/1ps
module cbt_can_cfg_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register bus
  input wire cbt_pkg::axi_req_s axiReq,
  output cbt_pkg::axi_rsp_s axiRsp,
  // Bus line
  input wire logic rxLine,
  input wire logic sampleStrobe,
  output logic sampledBit,
  // Events in flag layout, one-cycle pulses
  input wire logic [15:0] eventIn,
  // Configuration and status
  output cbt_pkg::timing_s timingCfg,
  output logic moduleOn,
  output logic [2:0] opMode,
  output logic irq
);

  typedef struct packed {
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rdAddr;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [2:0] opMode;
    logic onBit;
    logic [31:0] timing;
    logic [31:0] intReg;
    cbt_pkg::timing_s cfg;
  } cbt_state_s;

  cbt_state_s s_r;
  cbt_state_s s_nxt;
  logic [1:0] rstPipe_r;
  logic rstSyncN;
  logic wrGo;
  logic rdGo;
  logic modeChg;
  logic sysClr;
  logic wakeEvent;
  logic [15:0] clrBits;
  logic [15:0] evtBits;
  logic [15:0] flagNxt;
  logic [15:0] enWord;
  logic [31:0] word;

  // The reset is released through two flops so its removal is clean.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'h1};
    end
  end
  assign rstSyncN = rstPipe_r[1];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] ctrlImage(input logic [2:0] mode,
                                            input logic on);
    logic [31:0] res;
    res = 32'h0000_0000;
    res[cbt_pkg::OPMODE_LSB +: 3] = mode;
    res[cbt_pkg::ON_BIT] = on;
    return res;
  endfunction

  // Phase 2 follows phase 1 or the processing time when not selected.
  function automatic logic [31:0] autoPhase2(input logic [31:0] t);
    logic [31:0] res;
    logic [2:0] p1;
    res = t;
    p1 = t[cbt_pkg::P1LEN_LSB +: 3];
    if (!t[cbt_pkg::P2SEL_BIT]) begin
      res[cbt_pkg::P2LEN_LSB +: 3] =
        (p1 > cbt_pkg::IPT_CODE) ? p1 : cbt_pkg::IPT_CODE;
    end
    return res;
  endfunction

  function automatic cbt_pkg::timing_s derive(input logic [31:0] t);
    cbt_pkg::timing_s res;
    res.wakeFilterEn = t[cbt_pkg::WAKEFILT_BIT];
    res.tripleSampleEn = t[cbt_pkg::TRIPLE_BIT];
    res.phase1Quanta = {1'b0, t[cbt_pkg::P1LEN_LSB +: 3]} + 4'h1;
    res.phase2Quanta = {1'b0, t[cbt_pkg::P2LEN_LSB +: 3]} + 4'h1;
    res.lowBits = t[cbt_pkg::LOW_W-1:0];
    return res;
  endfunction

  assign wrGo = s_r.awHeld && s_r.wHeld && !s_r.bValid;
  assign rdGo = axiReq.arvalid && !s_r.rValid;

  // Write side effects that feed the interrupt flags.
  always_comb begin
    word = merge(32'h0000_0000, s_r.wData, s_r.wStrb);
    modeChg = 1'b0;
    sysClr = 1'b0;
    clrBits = 16'h0000;
    enWord = s_r.intReg[31:16];
    if (wrGo && s_r.awAddr == cbt_pkg::CTRL_OFS) begin
      word = merge(ctrlImage(s_r.opMode, s_r.onBit), s_r.wData, s_r.wStrb);
      modeChg = word[cbt_pkg::OPMODE_LSB +: 3] != s_r.opMode;
      sysClr = s_r.onBit && !word[cbt_pkg::ON_BIT];
    end else if (wrGo && s_r.awAddr == cbt_pkg::INT_OFS) begin
      word = merge(s_r.intReg, s_r.wData, s_r.wStrb);
      enWord = word[31:16] & cbt_pkg::INT_MASK[31:16];
      clrBits = 16'(merge(32'h0000_0000, s_r.wData, s_r.wStrb));
      clrBits[cbt_pkg::SYSERR_FLAG] = 1'b0;
    end
  end

  always_comb begin
    evtBits = eventIn & cbt_pkg::FLAG_MASK;
    evtBits[cbt_pkg::WAKE_FLAG] = eventIn[cbt_pkg::WAKE_FLAG] | wakeEvent;
    evtBits[cbt_pkg::MODE_FLAG] = eventIn[cbt_pkg::MODE_FLAG] | modeChg;
  end

  // Each flag: an event in the clearing cycle wins over the clear.
  for (genvar i = 0; i < 16; i++) begin : gFlag
    if (i == cbt_pkg::SYSERR_FLAG) begin : gSys
      assign flagNxt[i] = evtBits[i] | (s_r.intReg[i] & !sysClr);
    end else begin : gNorm
      assign flagNxt[i] = cbt_pkg::FLAG_MASK[i] &
        (evtBits[i] | (s_r.intReg[i] & !clrBits[i]));
    end
  end

  always_comb begin
    s_nxt = s_r;
    if (axiReq.awvalid && !s_r.awHeld) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !s_r.wHeld) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = axiReq.wdata;
      s_nxt.wStrb = axiReq.wstrb;
    end
    if (s_r.bValid && axiReq.bready) begin
      s_nxt.bValid = 1'b0;
    end
    if (s_r.rValid && axiReq.rready) begin
      s_nxt.rValid = 1'b0;
    end
    if (wrGo) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = cbt_pkg::RESP_OKAY;
      case (s_r.awAddr)
        cbt_pkg::CTRL_OFS: begin
          s_nxt.opMode = word[cbt_pkg::OPMODE_LSB +: 3];
          s_nxt.onBit = word[cbt_pkg::ON_BIT];
        end
        cbt_pkg::TIMING_OFS: begin
          if (s_r.opMode == cbt_pkg::OPMODE_CONFIG) begin
            s_nxt.timing = merge(s_r.timing, s_r.wData, s_r.wStrb) &
                           cbt_pkg::TIMING_MASK;
          end
        end
        cbt_pkg::INT_OFS: begin
        end
        default: begin
          s_nxt.bResp = cbt_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rdGo) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rdAddr = axiReq.araddr;
      s_nxt.rResp = cbt_pkg::RESP_OKAY;
      case (axiReq.araddr)
        cbt_pkg::CTRL_OFS: begin
          s_nxt.rData = ctrlImage(s_r.opMode, s_r.onBit);
        end
        cbt_pkg::TIMING_OFS: begin
          s_nxt.rData = s_r.timing & cbt_pkg::TIMING_MASK;
        end
        cbt_pkg::INT_OFS: begin
          s_nxt.rData = s_r.intReg & cbt_pkg::INT_MASK;
        end
        default: begin
          s_nxt.rData = 32'h0000_0000;
          s_nxt.rResp = cbt_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.timing = autoPhase2(s_nxt.timing);
    s_nxt.intReg = {enWord, flagNxt};
    s_nxt.cfg = derive(s_nxt.timing);
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_r <= '0;
      s_r.opMode <= cbt_pkg::OPMODE_RST;
      s_r.timing <= cbt_pkg::TIMING_RST;
      s_r.intReg <= cbt_pkg::INT_RST;
      s_r.cfg <= cbt_pkg::CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  cbt_rx_sampler uSampler (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .rxLine(rxLine),
    .sampleStrobe(sampleStrobe),
    .tripleEn(s_r.cfg.tripleSampleEn),
    .filterEn(s_r.cfg.wakeFilterEn),
    .sampledBit(sampledBit),
    .wakeEvent(wakeEvent)
  );

  always_comb begin
    axiRsp.awready = !s_r.awHeld;
    axiRsp.wready = !s_r.wHeld;
    axiRsp.bvalid = s_r.bValid;
    axiRsp.bresp = s_r.bResp;
    axiRsp.arready = !s_r.rValid;
    axiRsp.rvalid = s_r.rValid;
    axiRsp.rdata = s_r.rData;
    axiRsp.rresp = s_r.rResp;
  end

  assign timingCfg = s_r.cfg;
  assign moduleOn = s_r.onBit;
  assign opMode = s_r.opMode;
  assign irq = (s_r.intReg[15:0] & s_r.intReg[31:16]) != 16'h0000;

  cfg_lock_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    wrGo && s_r.awAddr == cbt_pkg::TIMING_OFS &&
    s_r.opMode != cbt_pkg::OPMODE_CONFIG |=> $stable(s_r.timing))
    else $error("timing changed outside configuration mode");
  cfg_write_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    wrGo && s_r.awAddr == cbt_pkg::TIMING_OFS && s_r.wStrb == 4'hF &&
    s_r.opMode == cbt_pkg::OPMODE_CONFIG && s_r.wData[cbt_pkg::P2SEL_BIT]
    |=> s_r.timing == $past(s_r.wData & cbt_pkg::TIMING_MASK))
    else $error("timing write in configuration mode lost");
  phase2_prog_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    s_r.timing[cbt_pkg::P2SEL_BIT] |-> timingCfg.phase2Quanta ==
    {1'b0, s_r.timing[cbt_pkg::P2LEN_LSB +: 3]} + 4'h1)
    else $error("programmed phase 2 length wrong");
  phase2_auto_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    !s_r.timing[cbt_pkg::P2SEL_BIT] |-> timingCfg.phase2Quanta ==
    ((timingCfg.phase1Quanta > cbt_pkg::IPT_QUANTA) ?
     timingCfg.phase1Quanta : cbt_pkg::IPT_QUANTA))
    else $error("automatic phase 2 length wrong");
  phase1_len_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    timingCfg.phase1Quanta ==
    {1'b0, s_r.timing[cbt_pkg::P1LEN_LSB +: 3]} + 4'h1)
    else $error("phase 1 length wrong");
  invalid_flag_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    eventIn[cbt_pkg::INVALID_FLAG] |=> s_r.intReg[cbt_pkg::INVALID_FLAG])
    else $error("invalid message flag not set");
  flag_clear_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    wrGo && s_r.awAddr == cbt_pkg::INT_OFS && s_r.wStrb[1] &&
    s_r.wData[cbt_pkg::INVALID_FLAG] && !eventIn[cbt_pkg::INVALID_FLAG]
    |=> !s_r.intReg[cbt_pkg::INVALID_FLAG])
    else $error("invalid message flag not cleared by a one");
  syserr_hold_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    s_r.intReg[cbt_pkg::SYSERR_FLAG] && !sysClr
    |=> s_r.intReg[cbt_pkg::SYSERR_FLAG])
    else $error("system error flag cleared without module restart");
  syserr_clear_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    sysClr && !eventIn[cbt_pkg::SYSERR_FLAG]
    |=> !s_r.intReg[cbt_pkg::SYSERR_FLAG])
    else $error("system error flag kept after module switched off");
  enable_write_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    wrGo && s_r.awAddr == cbt_pkg::INT_OFS && s_r.wStrb == 4'hF
    |=> s_r.intReg[31:16] ==
    $past(s_r.wData[31:16] & cbt_pkg::INT_MASK[31:16]))
    else $error("interrupt enable write lost");
  irq_level_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    s_r.intReg[cbt_pkg::INVALID_FLAG] && s_r.intReg[31] |-> irq)
    else $error("interrupt request missing");
  irq_quiet_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    s_r.intReg[31:16] == 16'h0000 |-> !irq)
    else $error("interrupt request with every enable clear");
  rd_reserved_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    axiRsp.rvalid && s_r.rdAddr == cbt_pkg::INT_OFS
    |-> (axiRsp.rdata & ~cbt_pkg::INT_MASK) == 32'h0000_0000)
    else $error("unimplemented interrupt bits read nonzero");
  rd_timing_a: assert property (
    @(posedge clock) disable iff (!rstSyncN)
    axiRsp.rvalid && s_r.rdAddr == cbt_pkg::TIMING_OFS
    |-> (axiRsp.rdata & ~cbt_pkg::TIMING_MASK) == 32'h0000_0000)
    else $error("unimplemented timing bits read nonzero");
  cfg_write_c: cover property (@(posedge clock) disable iff (!rstSyncN)
    wrGo && s_r.awAddr == cbt_pkg::TIMING_OFS &&
    s_r.opMode == cbt_pkg::OPMODE_CONFIG);
  irq_rise_c: cover property (@(posedge clock) disable iff (!rstSyncN)
    $rose(irq));
  syserr_clear_c: cover property (@(posedge clock) disable iff (!rstSyncN)
    sysClr && s_r.intReg[cbt_pkg::SYSERR_FLAG]);
  wake_flag_c: cover property (@(posedge clock) disable iff (!rstSyncN)
    wakeEvent && s_r.cfg.wakeFilterEn);

endmodule

/* verification/cbt_line_model.sv */
// Behavioural bus line and sample point source facing the block.
`timescale 1ns/1ps
module cbt_line_model (
  // Clock
  input wire logic clock,
  // Line toward the block
  output logic rxLine,
  output logic sampleStrobe
);
  // The line rests recessive, as the bus pull-up leaves it between frames.
  initial begin
    rxLine = 1'b1;
    sampleStrobe = 1'b0;
  end

  // Drives n levels, oldest first, one per cycle; strobes on the last one.
  task automatic send(input logic [7:0] lvls, input int n, input logic stb);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock);
      rxLine <= lvls[i];
      sampleStrobe <= stb && (i == 0);
    end
    @(posedge clock);
    rxLine <= 1'b1;
    sampleStrobe <= 1'b0;
  endtask
endmodule

/* verification/cbt_can_cfg_top_test.sv */
// Self-checking bench for the bus timing and interrupt register block.
`timescale 1ns/1ps
module cbt_can_cfg_top_test;
  `define CHK(nm, ex, got) begin compares++; \
    if ((got) !== (ex)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

  logic clock = 1'b0;
  logic rstn = 1'b0;
  cbt_pkg::axi_req_s req = '0;
  cbt_pkg::axi_rsp_s rsp;
  logic [15:0] evt = 16'h0000;
  logic rxLine, sampleStrobe, sampledBit, moduleOn, irq;
  logic [2:0] opMode;
  cbt_pkg::timing_s timingCfg;
  logic [31:0] curTiming;
  int num_errors = 0;
  int compares = 0;

  cbt_can_cfg_top u_cbt_can_cfg_top (.clock(clock), .rstn(rstn),
    .axiReq(req), .axiRsp(rsp), .rxLine(rxLine),
    .sampleStrobe(sampleStrobe), .sampledBit(sampledBit), .eventIn(evt),
    .timingCfg(timingCfg), .moduleOn(moduleOn), .opMode(opMode),
    .irq(irq));
  cbt_line_model u_cbt_line_model (.clock(clock), .rxLine(rxLine),
    .sampleStrobe(sampleStrobe));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic timedOut();
    num_errors++;
    $display("ERROR bus wait expected answer seen none");
    conclude();
  endtask

  task automatic axWrite(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    if (rsp.bvalid !== 1'b1) timedOut();
  endtask

  task automatic axRead(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    if (rsp.rvalid !== 1'b1) timedOut();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axWrite(a, d, r);
    `CHK("write response", cbt_pkg::RESP_OKAY, r)
  endtask

  task automatic expRd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axRead(a, d, r);
    `CHK("read response", cbt_pkg::RESP_OKAY, r)
    `CHK("read data", e, d)
  endtask

  task automatic ctrl(input logic [2:0] m, input logic on);
    wr(cbt_pkg::CTRL_OFS, {8'h00, m, 5'h00, on, 15'h0000});
    `CHK("mode", m, opMode)
    `CHK("module on", on, moduleOn)
  endtask

  // Keeps software-side timing limits so every value is a legal setup.
  function automatic logic [31:0] legal(input logic [31:0] r);
    logic [31:0] v;
    v = r;
    v[10:8] = 3'h7;
    v[7:6] = 2'h0;
    if (v[5:0] < 6'h02) v[5:0] = 6'h02;
    if (v[18:16] > v[13:11]) v[18:16] = v[13:11];
    return v;
  endfunction

  task automatic chkTiming(input logic [31:0] v);
    logic [31:0] e;
    e = v & 32'h0047_FFFF;
    if (!e[15]) begin
      e[18:16] = e[13:11];
      if (e[13:11] < cbt_pkg::IPT_CODE) e[18:16] = cbt_pkg::IPT_CODE;
    end
    curTiming = e;
    wr(cbt_pkg::TIMING_OFS, v);
    expRd(cbt_pkg::TIMING_OFS, e);
    `CHK("p1 quanta", {1'b0, e[13:11]} + 4'h1, timingCfg.phase1Quanta)
    `CHK("p2 quanta", {1'b0, e[18:16]} + 4'h1, timingCfg.phase2Quanta)
    `CHK("triple", e[14], timingCfg.tripleSampleEn)
    `CHK("wake filter", e[22], timingCfg.wakeFilterEn)
    `CHK("low bits", e[10:0], timingCfg.lowBits)
  endtask

  initial begin
    logic [31:0] v;
    logic [31:0] e;
    logic [1:0] r;
    logic [15:0] impl;
    logic stuck;
    v = $urandom(32'h3635CDFF);
    impl = 16'hF80F;
    stuck = 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    expRd(cbt_pkg::CTRL_OFS, 32'h0000_0000);
    expRd(cbt_pkg::TIMING_OFS, 32'h0001_0000);
    expRd(cbt_pkg::INT_OFS, 32'h0000_0000);
    wr(cbt_pkg::TIMING_OFS, 32'h0000_C707);
    expRd(cbt_pkg::TIMING_OFS, 32'h0001_0000);
    ctrl(3'h4, 1'b1);
    chkTiming(32'h0000_0707);
    chkTiming(legal(32'hFFFF_FFFF));
    repeat (12) chkTiming(legal($urandom()));
    ctrl(3'h0, 1'b1);
    wr(cbt_pkg::TIMING_OFS, ~curTiming);
    expRd(cbt_pkg::TIMING_OFS, curTiming);
    ctrl(3'h4, 1'b1);
    for (int t = 0; t < 4; t++) begin
      chkTiming({17'h00000, t[1], 14'h3F07});
      u_cbt_line_model.send(t[0] ? 8'h01 : 8'h1E, 5, 1'b1);
      #1;
      `CHK("sampled bit", t[1] ? ~t[0] : t[0], sampledBit)
    end
    for (int k = 0; k < 3; k++) begin
      chkTiming({9'h000, k > 0, 22'h003F07});
      wr(cbt_pkg::INT_OFS, 32'h0000_FFFF);
      u_cbt_line_model.send(8'h00, k == 1 ? 4 : (k == 2 ? 6 : 1), 1'b0);
      repeat (4) @(posedge clock);
      expRd(cbt_pkg::INT_OFS, {17'h00000, k != 1, 14'h0000});
    end
    // The last wake-up flag must not leak into the per-event checks.
    wr(cbt_pkg::INT_OFS, 32'h0000_FFFF);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clock);
      evt <= 16'h0001 << i;
      @(posedge clock);
      evt <= 16'h0000;
      if (i == 12) stuck = 1'b1;
      e = {16'h0000, impl & (16'h0001 << i)} | {19'h00000, stuck, 12'h000};
      expRd(cbt_pkg::INT_OFS, e);
      `CHK("irq masked", 1'b0, irq)
      wr(cbt_pkg::INT_OFS, 32'h0000_0001 << (i + 16));
      expRd(cbt_pkg::INT_OFS, e | {impl & (16'h0001 << i), 16'h0000});
      `CHK("irq enabled", impl[i], irq)
      wr(cbt_pkg::INT_OFS, (32'h0000_0001 << (i + 16)) | (32'h1 << i));
      `CHK("irq cleared", i == 12, irq)
      wr(cbt_pkg::INT_OFS, 32'h0000_0000);
    end
    ctrl(3'h4, 1'b0);
    expRd(cbt_pkg::INT_OFS, 32'h0000_0000);
    ctrl(3'h2, 1'b1);
    expRd(cbt_pkg::INT_OFS, 32'h0000_0008);
    axWrite(8'h0C, 32'hFFFF_FFFF, r);
    `CHK("unmapped write", cbt_pkg::RESP_SLVERR, r)
    axRead(8'h0C, v, r);
    `CHK("unmapped read", cbt_pkg::RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0000_0000, v)
    conclude();
  end
endmodule
